// File: inc/rdc_pkg.sv
// Package for the redriver channel control register bank: map, resets, types.
// Assumes a two-wire serial bus host and a 100 MHz system clock in the device.
// How it works
// - Byte 8: receive-detect powerdown in 7..4 (default 1), receiver reset 3..0 (0).
// - Byte 9: detector off bits 7..4, default 0; bits 3..0 plain storage.
// - Byte 0x0A: two threshold bits per channel, channel 3 in bits 7..6.
// - Channel 0 threshold in bits 1..0; all threshold bits reset to 0.
// - Only block reads and writes starting at byte 0 are supported.
// - The first data byte of a write is a dummy offset and ignored.
// - Target address is 1,1,strap4,0,0,strap1,strap0, then read/write bit.
// - Byte 0 shows channel activity in bits 7..4, bits 3..0 zero.
package rdc_pkg;

  localparam logic [3:0] OFS_STATUS = 4'h0;
  localparam logic [3:0] OFS_LOW_FIRST = 4'h2;
  localparam logic [3:0] OFS_LOW_LAST = 4'h6;
  localparam logic [3:0] OFS_RSVD7 = 4'h7; // reserved_byte_seven
  localparam logic [3:0] OFS_RXCTL = 4'h8; // rx_powerdown_and_reset
  localparam logic [3:0] OFS_DETCTL = 4'h9; // activity_detector_control
  localparam logic [3:0] OFS_THRESH = 4'hA; // activity_threshold_select

  localparam logic [7:0] RST_RXCTL = 8'hF0;
  localparam logic [7:0] RST_DETCTL = 8'h00;
  localparam logic [7:0] RST_THRESH = 8'h00;
  localparam logic [7:0] RST_LOWER = 8'h00;

  localparam logic [1:0] ADDR_HIGH_BITS = 2'h3;
  localparam logic [1:0] ADDR_MID_BITS = 2'h0;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int LOWER_BYTES = 5;

  typedef struct packed {
    logic [3:0] receive_detect_powerdown;
    logic [3:0] rx_reset;
    logic [3:0] detector_off;
    logic [3:0] spare;
    logic [3:0] threshold_sel_high;
    logic [3:0] threshold_sel_low;
  } rdc_ctrl_t;

  localparam rdc_ctrl_t CTRL_RST = {RST_RXCTL, RST_DETCTL, RST_THRESH};

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_ADDR = 7'h02,
    ST_AACK = 7'h04,
    ST_WDATA = 7'h08,
    ST_WACK = 7'h10,
    ST_RDATA = 7'h20,
    ST_RACK = 7'h40
  } rdc_state_t;

  // Interleave per-channel threshold bits, high select above low
  function automatic logic [7:0] rdc_thresh_pack(input logic [3:0] hi, input logic [3:0] lo);
    logic [7:0] b;
    b = 8'h00;
    for (int i = 0; i < 4; i++) begin
      b[2*i+1] = hi[i];
      b[2*i] = lo[i];
    end
    return b;
  endfunction

  function automatic logic [3:0] rdc_thresh_pick(input logic [7:0] b, input logic upper);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 0; i < 4; i++) begin
      r[i] = upper ? b[2*i+1] : b[2*i];
    end
    return r;
  endfunction

endpackage

// File: rtl/rdc_sync.sv
// Two-flop synchroniser for a group of asynchronous inputs.
// Assumes inputs come from pins outside the clk domain.
`timescale 1ns/10ps
module rdc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk,            // System clock
  input wire logic reset_n,        // Synchronous reset, active low
  input wire logic [W-1:0] async_in, // Raw pin levels
  output logic [W-1:0] sync_out    // Levels in the clk domain
);
  logic [W-1:0] stage1;

  if (W < 1) begin : g_bad_width
    $error("rdc_sync needs W of at least 1");
  end

  // First stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      stage1 <= INIT;
      sync_out <= INIT;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule

// File: rtl/rdc_regs.sv
// Serial-bus slave and channel control register bank of the redriver.
// Assumes bus pins and straps arrive asynchronously; open-drain data pin
// resolved outside from sda_oe; no clock stretching.
`timescale 1ns/10ps
module rdc_regs
  import rdc_pkg::*;
(
  input wire logic clk,                 // 100 MHz system clock
  input wire logic reset_n,             // Synchronous reset, active low
  input wire logic scl_in,              // Bus clock pin level
  input wire logic sda_in,              // Bus data pin level
  output logic sda_out,                 // Bus data drive value, always low
  output logic sda_oe,                  // High while pulling data low
  input wire logic strap_addr_bit4,     // Address strap pin
  input wire logic strap_addr_bit1,     // Address strap pin
  input wire logic strap_addr_bit0,     // Address strap pin
  input wire logic [3:0] activity_in,   // Per-channel activity detector levels
  output rdc_ctrl_t ctrl,               // Channel control fields
  output logic [LOWER_BYTES-1:0][7:0] lower_cfg // Bytes 2..6 storage
);
  logic [8:0] sync_q;
  logic scl_s, sda_s, scl_d, sda_d;
  logic [3:0] act_s;
  logic [6:0] dev_addr;
  logic start_det, stop_det, scl_rise, scl_fall;
  rdc_state_t state;
  logic [3:0] cnt;
  logic [7:0] sh, tx, rd_data;
  logic [3:0] ptr, low_idx;
  logic rw, nack, dummy;
  logic wr_en, rd_load, addr_hit;

  rdc_sync #(.W(9), .INIT(9'h003)) u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .async_in({activity_in, strap_addr_bit4, strap_addr_bit1, strap_addr_bit0, sda_in, scl_in}),
    .sync_out(sync_q)
  );

  assign scl_s = sync_q[0];
  assign sda_s = sync_q[1];
  assign act_s = sync_q[8:5];
  assign dev_addr = {ADDR_HIGH_BITS, sync_q[4], ADDR_MID_BITS,
    sync_q[3], sync_q[2]};

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  assign start_det = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_det = scl_s & scl_d & ~sda_d & sda_s;
  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign addr_hit = (sh[7:1] == dev_addr);
  assign wr_en = scl_fall && state == ST_WDATA && cnt == BITS_PER_BYTE && !dummy;
  assign rd_load = scl_fall && ((state == ST_AACK && rw) || (state == ST_RACK && !nack));
  assign low_idx = ptr - OFS_LOW_FIRST;

  // Byte presented to the host at the pointer
  always_comb begin
    rd_data = 8'h00;
    if (ptr == OFS_STATUS) begin
      rd_data = {act_s, 4'h0};
    end else if (ptr >= OFS_LOW_FIRST && ptr <= OFS_LOW_LAST) begin
      rd_data = lower_cfg[low_idx[2:0]];
    end else if (ptr == OFS_RXCTL) begin
      rd_data = {ctrl.receive_detect_powerdown, ctrl.rx_reset};
    end else if (ptr == OFS_DETCTL) begin
      rd_data = {ctrl.detector_off, ctrl.spare};
    end else if (ptr == OFS_THRESH) begin
      rd_data = rdc_thresh_pack(ctrl.threshold_sel_high, ctrl.threshold_sel_low);
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
    end
  end

  // Bus protocol engine
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      cnt <= 4'h0;
      sh <= 8'h00;
      tx <= 8'h00;
      ptr <= OFS_STATUS;
      rw <= 1'b0;
      nack <= 1'b0;
      dummy <= 1'b0;
      sda_oe <= 1'b0;
    end else if (start_det) begin
      state <= ST_ADDR;
      cnt <= 4'h0;
      ptr <= OFS_STATUS;
      dummy <= 1'b1;
      sda_oe <= 1'b0;
    end else if (stop_det) begin
      state <= ST_IDLE;
      sda_oe <= 1'b0;
    end else if (scl_rise) begin
      if (state == ST_ADDR || state == ST_WDATA) begin
        sh <= {sh[6:0], sda_s};
        cnt <= cnt + 4'h1;
      end
      if (state == ST_RDATA) begin
        cnt <= cnt + 4'h1;
      end
      if (state == ST_RACK) begin
        nack <= sda_s;
      end
    end else if (rd_load) begin
      state <= ST_RDATA;
      tx <= rd_data;
      sda_oe <= ~rd_data[7];
      ptr <= ptr + 4'h1;
      cnt <= 4'h0;
    end else if (scl_fall) begin
      unique case (state)
        ST_IDLE: begin
        end
        ST_ADDR: begin
          if (cnt == BITS_PER_BYTE) begin
            if (addr_hit) begin
              state <= ST_AACK;
              rw <= sh[0];
              sda_oe <= 1'b1;
            end else begin
              state <= ST_IDLE;
            end
          end
        end
        ST_AACK: begin
          state <= ST_WDATA;
          cnt <= 4'h0;
          sda_oe <= 1'b0;
        end
        ST_WDATA: begin
          if (cnt == BITS_PER_BYTE) begin
            state <= ST_WACK;
            sda_oe <= 1'b1;
            dummy <= 1'b0;
            if (!dummy) begin
              ptr <= ptr + 4'h1;
            end
          end
        end
        ST_WACK: begin
          state <= ST_WDATA;
          cnt <= 4'h0;
          sda_oe <= 1'b0;
        end
        ST_RDATA: begin
          if (cnt == BITS_PER_BYTE) begin
            state <= ST_RACK;
            sda_oe <= 1'b0;
          end else begin
            tx <= {tx[6:0], 1'b0};
            sda_oe <= ~tx[6];
          end
        end
        ST_RACK: begin
          state <= ST_IDLE;
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // Register bank writes
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ctrl <= CTRL_RST;
      for (int i = 0; i < LOWER_BYTES; i++) begin
        lower_cfg[i] <= RST_LOWER;
      end
    end else if (wr_en) begin
      if (ptr >= OFS_LOW_FIRST && ptr <= OFS_LOW_LAST) begin
        lower_cfg[low_idx[2:0]] <= sh;
      end else if (ptr == OFS_RXCTL) begin
        ctrl.receive_detect_powerdown <= sh[7:4];
        ctrl.rx_reset <= sh[3:0];
      end else if (ptr == OFS_DETCTL) begin
        ctrl.detector_off <= sh[7:4];
        ctrl.spare <= sh[3:0];
      end else if (ptr == OFS_THRESH) begin
        ctrl.threshold_sel_high <= rdc_thresh_pick(sh, 1'b1);
        ctrl.threshold_sel_low <= rdc_thresh_pick(sh, 1'b0);
      end
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  a_reset_values: assert property ($rose(reset_n) |-> ctrl == CTRL_RST)
    else $error("control fields not at reset values");
  a_rxctl_write: assert property (wr_en && ptr == OFS_RXCTL |=>
    {ctrl.receive_detect_powerdown, ctrl.rx_reset} == $past(sh))
    else $error("byte 8 write not stored");
  a_detctl_write: assert property (wr_en && ptr == OFS_DETCTL |=>
    ctrl.detector_off == $past(sh[7:4]) && ctrl.spare == $past(sh[3:0]))
    else $error("byte 9 write not stored");
  a_thresh_map: assert property (wr_en && ptr == OFS_THRESH |=>
    ctrl.threshold_sel_high[3] == $past(sh[7]) && ctrl.threshold_sel_low[3] == $past(sh[6])
    && ctrl.threshold_sel_high[0] == $past(sh[1]) && ctrl.threshold_sel_low[0] == $past(sh[0]))
    else $error("threshold bits misplaced");
  a_reserved_write: assert property (wr_en
    && (ptr == OFS_RSVD7 || ptr > OFS_THRESH) |=>
    $stable(ctrl) && $stable(lower_cfg) && ptr == $past(ptr) + 4'h1)
    else $error("reserved byte write had an effect");
  a_dummy_ignored: assert property (scl_fall && state == ST_WDATA
    && cnt == BITS_PER_BYTE && dummy |=> $stable(ctrl) && ptr == OFS_STATUS && !dummy)
    else $error("dummy byte was used");
  a_start_ptr: assert property (start_det |=>
    ptr == OFS_STATUS && state == ST_ADDR)
    else $error("pointer not at byte 0 after start");
  a_addr_ack: assert property (scl_fall && state == ST_ADDR
    && cnt == BITS_PER_BYTE && !start_det && !stop_det |=>
    sda_oe == $past(addr_hit) && (state == ST_AACK) == $past(addr_hit))
    else $error("address match response wrong");
  a_status_read: assert property (rd_load && ptr == OFS_STATUS |=>
    tx == {$past(act_s), 4'h0} ##1 1'b1)
    else $error("status byte wrong");

  c_thresh_write: cover property (wr_en && ptr == OFS_THRESH);
  c_status_read: cover property (rd_load && ptr == OFS_STATUS);
  c_read_nack: cover property (scl_fall && state == ST_RACK && nack);
  c_reserved_pass: cover property (wr_en && ptr == OFS_RSVD7);
endmodule

// File: tb/rdc_host.sv
// Two-wire bus host model: drives the bus clock and pulls data low.
// Assumes the bench resolves the data line with a pull-up.
`timescale 1ns/10ps
module rdc_host (
  input wire logic clk, // Bench clock used for pacing
  input wire logic sda, // Resolved data line
  output logic scl,     // Bus clock, host driven
  output logic pull_low // High while host pulls data low
);
  // Both bus lines released; called once before the first transfer
  task automatic bus_idle();
    scl = 1'b1;
    pull_low = 1'b0;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Phases of 25 clk and more stay well above the sync minimum
  task automatic bit_io(input logic b, output logic r);
    pull_low = ~b;
    wt(25);
    scl = 1'b1;
    wt(35);
    r = sda;
    scl = 1'b0;
    wt(25);
  endtask
  // Every transfer opens with a start, so the pointer begins at byte 0
  task automatic start();
    pull_low = 1'b0;
    scl = 1'b1;
    wt(35);
    pull_low = 1'b1;
    wt(35);
    scl = 1'b0;
    wt(25);
  endtask
  task automatic stop();
    pull_low = 1'b1;
    wt(25);
    scl = 1'b1;
    wt(35);
    pull_low = 1'b0;
    wt(60);
  endtask
  // Sends d MSB first while sampling the line, then the ack bit ab
  task automatic xfer(input logic [7:0] d, input logic ab, output logic [7:0] q,
    output logic a);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(ab, a);
  endtask
endmodule

// File: tb/testbench.sv
// Self-checking bench for the channel control register bank over the serial bus.
// Assumes rdc_host as bus host; the data line pull-up is modelled here.
`timescale 1ns/10ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fail_count++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module testbench
  import rdc_pkg::*;
;
  logic clk, reset_n, scl, host_low, sda, sda_out, sda_oe, s4, s1, s0;
  logic [3:0] act;
  rdc_ctrl_t ctrl, ex;
  logic [LOWER_BYTES-1:0][7:0] lower_cfg;
  logic [7:0] img [16];
  int fail_count, checked;
  assign sda = (host_low || (sda_oe && !sda_out)) ? 1'b0 : 1'b1;
  rdc_host host (.clk(clk), .sda(sda), .scl(scl), .pull_low(host_low));
  rdc_regs dut (.clk(clk), .reset_n(reset_n), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .strap_addr_bit4(s4), .strap_addr_bit1(s1),
    .strap_addr_bit0(s0), .activity_in(act), .ctrl(ctrl), .lower_cfg(lower_cfg));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [6:0] dev_addr();
    return {2'b11, s4, 2'b00, s1, s0};
  endfunction
  function automatic logic writable(input int i);
    return (i >= 2 && i <= 6) || (i >= 8 && i <= 10);
  endfunction
  task automatic end_of_test();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic check_ports();
    for (int k = 0; k < 4; k++) begin
      ex.threshold_sel_high[k] = img[10][2*k+1];
      ex.threshold_sel_low[k] = img[10][2*k];
    end
    {ex.receive_detect_powerdown, ex.rx_reset} = img[8];
    {ex.detector_off, ex.spare} = img[9];
    `CHK(ctrl, ex)
    for (int k = 0; k < LOWER_BYTES; k++) begin
      `CHK(lower_cfg[k], img[k+2])
    end
    // Between transfers the data line is released
    `CHK({sda_oe, sda_out}, 2'b00)
  endtask
  task automatic wr_block(input logic [6:0] a, input logic [7:0] dummy, input int n);
    logic [7:0] q, d;
    logic k;
    host.start();
    host.xfer({a, 1'b0}, 1'b1, q, k);
    `CHK(k, (a === dev_addr()) ? 1'b0 : 1'b1)
    if (k === 1'b0) begin
      host.xfer(dummy, 1'b1, q, k);
      `CHK(k, 1'b0)
      for (int i = 0; i < n; i++) begin
        d = 8'($urandom);
        host.xfer(d, 1'b1, q, k);
        img[i] = writable(i) ? d : img[i];
        `CHK(k, 1'b0)
      end
    end
    host.stop();
  endtask
  task automatic rd_block(input int n);
    logic [7:0] q;
    logic k;
    host.start();
    host.xfer({dev_addr(), 1'b1}, 1'b1, q, k);
    `CHK(k, 1'b0)
    for (int i = 0; i < n; i++) begin
      host.xfer(8'hFF, i == n - 1, q, k);
      `CHK(q, (i == 0) ? {act, 4'h0} : img[i])
    end
    host.stop();
  endtask
  initial begin
    fail_count = 0;
    checked = 0;
    host.bus_idle();
    reset_n = 1'b0;
    act = 4'h0;
    {s4, s1, s0} = 3'h0;
    void'($urandom(32'h9831));
    foreach (img[i]) img[i] = 8'h00;
    img[8] = 8'hF0;
    act = 4'($urandom);
    {s4, s1, s0} = 3'($urandom);
    repeat (20) @(posedge clk);
    #1;
    reset_n = 1'b1;
    check_ports();
    rd_block(16);
    // Dummy byte equal to a register offset must not steer the pointer
    wr_block(dev_addr(), 8'h0A, 16);
    check_ports();
    act = 4'($urandom);
    {s4, s1, s0} = 3'($urandom);
    rd_block(16);
    wr_block(dev_addr(), 8'($urandom), 11);
    check_ports();
    rd_block(11);
    // Wrong fixed address bit: no ack, nothing written
    wr_block(dev_addr() ^ 7'h08, 8'h00, 0);
    check_ports();
    end_of_test();
  end
  initial begin
    #900000;
    fail_count++;
    end_of_test();
  end
endmodule
